/* File: hw/rsc_ref_status_clock_select.sv */
// How it works
// [R01] Primary beyond 12 ppm sets status bit 7.
// [R02] Hysteresis on indication, refreshed once per second.
// [R03] Monitoring always runs, independent of filter select.
// [R04] Thresholds follow oscillator unless calibration compensates.
// [R05] Secondary beyond 12 ppm sets status bit 6.
// [R06] Core lock within 142 ppm drives bit 5.
// [R07] Holdover operation drives status bit 4.
// [R08] Core at 104 ppm tracking edge drives bit 2.
// [R09] Limit bit may toggle briefly; tolerate it.
// [R10] Control bit 7 low: diff out, low rates.
// [R11] Control bit 7 high: diff off, LOW_RATE_CLOCK_SELECT rates.
// [R12] Bit 7 high: bit 6 picks 44.736/34.368.
// [R13] Bit 7 low: bit 6 picks 11.184/8.592.
// [R14] Four status bits mirrored on software-enabled pins.
// [R15] Status reads do not clear; reserved read zero.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "rsc_defs.svh"

module rsc_ref_status_clock_select #(
  parameter int unsigned TICK_CYCLES = `RSC_TICK_CYCLES  // Cycles per refresh period.
) (
  input  wire logic                 clk_sys,              // System clock, 25 MHz.
  input  wire logic                 arst_n,               // Asynchronous reset, active low.
  input  wire rsc_pkg::rsc_bus_req_t bus,                 // Host port request.
  output wire logic [7:0]           rd_data,              // Read data, one cycle after read.
  input  wire rsc_pkg::rsc_mon_t    mon,                  // Measured frequency offsets.
  input  wire logic                 sw_control,           // High enables the status pins.
  output wire rsc_pkg::rsc_pins_t   pins,                 // Dedicated status pins.
  output wire logic                 diff_155m_output_oe,  // High drives the 155 MHz pair.
  output wire rsc_pkg::rsc_rate_t   combined_rate_output, // Combined pin rate select.
  output wire logic                 irq                   // Level interrupt, active high.
);

  localparam logic [24:0] TICK_LAST = 25'(TICK_CYCLES - 1);

  rsc_pkg::rsc_state_t state_q;
  rsc_pkg::rsc_state_t state_d;

  logic [16:0] pri_adj;
  logic [16:0] sec_adj;
  logic [16:0] pri_mag;
  logic [16:0] sec_mag;
  logic [16:0] core_mag;
  logic        tick;
  logic        lock_now;
  logic        tracking_range_limit_now;
  logic [7:0]  new_status;
  logic [7:0]  status_chg;
  logic [7:0]  w1c;

  // Magnitude of a 17-bit two's complement value.
  function automatic logic [16:0] rsc_abs(input logic [16:0] v);
    rsc_abs = v[16] ? 17'((~v) + 17'h00001) : v;
  endfunction

  // Oscillator error shifts every measurement alike; the calibration value
  // is added to the primary and secondary offsets, not the core, before their thresholds.
  assign pri_adj  = {mon.primary_offset[15], mon.primary_offset}
                    + {{9{state_q.cal[7]}}, state_q.cal};  // R04
  assign sec_adj  = {mon.secondary_offset[15], mon.secondary_offset}
                    + {{9{state_q.cal[7]}}, state_q.cal};  // R04
  assign pri_mag  = rsc_abs(pri_adj);
  assign sec_mag  = rsc_abs(sec_adj);
  assign core_mag = rsc_abs({mon.core_offset[15], mon.core_offset});

  // The refresh tick is free running and never gated by mode or filter.
  assign tick     = (state_q.tick_cnt == TICK_LAST);  // R03
  assign lock_now = (core_mag <= `RSC_LOCK_TPPM);  // R06
  // No filtering here: a brief toggle near the limit is passed on as is.
  assign tracking_range_limit_now = (core_mag >= `RSC_TRACKING_RANGE_LIMIT_TPPM);  // R08 R09

  // Next state: monitors, status, interrupts and the register file.
  always_comb begin
    state_d = state_q;
    new_status = state_q.status;
    w1c = 8'h00;
    state_d.tick_cnt = tick ? 25'h0000000 : 25'(state_q.tick_cnt + 25'h0000001);
    // Acceptance range holds between ticks; set above 12 ppm, clear below 11.
    if (tick) begin
      new_status[`RSC_BIT_PRI] = state_q.status[`RSC_BIT_PRI]
                                 ? (pri_mag >= `RSC_OOR_CLR_TPPM)
                                 : (pri_mag > `RSC_OOR_SET_TPPM);  // R01 R02
      new_status[`RSC_BIT_SEC] = state_q.status[`RSC_BIT_SEC]
                                 ? (sec_mag >= `RSC_OOR_CLR_TPPM)
                                 : (sec_mag > `RSC_OOR_SET_TPPM);  // R05 R02
    end
    new_status[`RSC_BIT_LOCK] = lock_now;  // R06
    new_status[`RSC_BIT_HOLD] = mon.holdover;  // R07
    new_status[`RSC_BIT_TRACKING_RANGE_LIMIT] = tracking_range_limit_now;  // R08
    new_status = new_status & `RSC_STATUS_MASK;  // R15
    status_chg = new_status ^ state_q.status;
    state_d.status = new_status;
    if (bus.wr) begin
      case (bus.addr)
        `RSC_ADDR_RATE:     state_d.rate = bus.wdata & `RSC_RATE_WMASK;
        `RSC_ADDR_OSC_CAL:  state_d.cal = bus.wdata;  // R04
        `RSC_ADDR_IRQ_MASK: state_d.irq_mask = bus.wdata & `RSC_STATUS_MASK;
        `RSC_ADDR_IRQ_STAT: w1c = bus.wdata;
        default:            state_d.rate = state_q.rate;
      endcase
    end
    // A change arriving with its clear still sets the sticky bit.
    state_d.irq_stat = ((state_q.irq_stat & ~w1c) | status_chg) & `RSC_STATUS_MASK;
    // Reads have no side effect; unmapped addresses return zero.
    state_d.rd_data = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `RSC_ADDR_STATUS:   state_d.rd_data = state_q.status;  // R15
        `RSC_ADDR_RATE:     state_d.rd_data = state_q.rate;
        `RSC_ADDR_IRQ_STAT: state_d.rd_data = state_q.irq_stat;
        `RSC_ADDR_IRQ_MASK: state_d.rd_data = state_q.irq_mask;
        `RSC_ADDR_OSC_CAL:  state_d.rd_data = state_q.cal;
        default:            state_d.rd_data = 8'h00;
      endcase
    end
    // Output selection follows the rate register in the same cycle.
    state_d.diff_oe = ~state_d.rate[`RSC_BIT_HS_SEL];  // R10 R11
    case ({state_d.rate[`RSC_BIT_HS_SEL], state_d.rate[`RSC_BIT_LR_SEL]})
      2'b11:   state_d.rate_out = rsc_pkg::RSC_RATE_34M368;  // R12
      2'b10:   state_d.rate_out = rsc_pkg::RSC_RATE_44M736;  // R12
      2'b01:   state_d.rate_out = rsc_pkg::RSC_RATE_8M592;  // R13
      default: state_d.rate_out = rsc_pkg::RSC_RATE_11M184;  // R13
    endcase
    // Pins stay low unless software control is active.
    state_d.pins.primary_out_of_range   = sw_control & new_status[`RSC_BIT_PRI];  // R14
    state_d.pins.secondary_out_of_range = sw_control & new_status[`RSC_BIT_SEC];  // R14
    state_d.pins.core_pll_locked        = sw_control & new_status[`RSC_BIT_LOCK];  // R14
    state_d.pins.holdover               = sw_control & new_status[`RSC_BIT_HOLD];  // R14
  end

  // State register.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q.rate     <= `RSC_RATE_RESET;
      state_q.cal      <= `RSC_CAL_RESET;
      state_q.status   <= 8'h00;
      state_q.irq_stat <= `RSC_IRQ_RESET;
      state_q.irq_mask <= `RSC_IRQ_RESET;
      state_q.tick_cnt <= 25'h0000000;
      state_q.rd_data  <= 8'h00;
      state_q.pins     <= 4'h0;
      state_q.diff_oe  <= 1'b1;
      state_q.rate_out <= rsc_pkg::RSC_RATE_11M184;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs come straight from the state register; irq is the OR of the sticky bits ANDed with the mask.
  assign rd_data              = state_q.rd_data;
  assign pins                 = state_q.pins;
  assign diff_155m_output_oe  = state_q.diff_oe;
  assign combined_rate_output = state_q.rate_out;
  assign irq                  = |(state_q.irq_stat & state_q.irq_mask);

  // Checks on the indications and the register file.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  a_pri_set_above: assert property ( // R01
    tick && !state_q.status[`RSC_BIT_PRI] && (pri_mag > `RSC_OOR_SET_TPPM)
    |=> state_q.status[`RSC_BIT_PRI])
    else $error("Primary out-of-range bit did not set above threshold.");

  a_pri_only_tick: assert property ( // R02
    !tick |=> $stable(state_q.status[`RSC_BIT_PRI]))
    else $error("Primary out-of-range bit changed between ticks.");

  a_sec_hysteresis: assert property ( // R05
    tick && state_q.status[`RSC_BIT_SEC] && (sec_mag >= `RSC_OOR_CLR_TPPM)
    |=> state_q.status[`RSC_BIT_SEC])
    else $error("Secondary out-of-range bit cleared inside hysteresis band.");

  a_tick_period: assert property ( // R03
    tick |=> !tick [*2])
    else $error("Refresh tick came too soon.");

  a_lock_track: assert property ( // R06
    1'b1 |=> state_q.status[`RSC_BIT_LOCK] == $past(lock_now))
    else $error("Lock bit does not follow core offset.");

  a_hold_track: assert property ( // R07
    1'b1 |=> state_q.status[`RSC_BIT_HOLD] == $past(mon.holdover))
    else $error("Holdover bit does not follow holdover state.");

  a_tracking_range_limit_track: assert property ( // R08
    1'b1 |=> state_q.status[`RSC_BIT_TRACKING_RANGE_LIMIT] == $past(tracking_range_limit_now))
    else $error("Frequency limit bit does not follow core offset.");

  a_diff_enable: assert property ( // R10
    diff_155m_output_oe == ~state_q.rate[`RSC_BIT_HS_SEL])
    else $error("Differential enable disagrees with rate select.");

  a_rate_map: assert property ( // R12
    state_q.rate[`RSC_BIT_HS_SEL] |-> (state_q.rate[`RSC_BIT_LR_SEL]
      ? combined_rate_output == rsc_pkg::RSC_RATE_34M368
      : combined_rate_output == rsc_pkg::RSC_RATE_44M736))
    else $error("High-speed rate mapping wrong.");

  a_low_rate_map: assert property ( // R13
    !state_q.rate[`RSC_BIT_HS_SEL] |-> (state_q.rate[`RSC_BIT_LR_SEL]
      ? combined_rate_output == rsc_pkg::RSC_RATE_8M592
      : combined_rate_output == rsc_pkg::RSC_RATE_11M184))
    else $error("Low-rate mapping wrong.");

  a_pins_gate: assert property ( // R14
    !sw_control |=> (pins == 4'h0))
    else $error("Status pins active outside software control.");

  a_read_status: assert property ( // R15
    bus.rd && (bus.addr == `RSC_ADDR_STATUS)
    |=> (rd_data == $past(state_q.status)) && (rd_data[3] == 1'b0)
        && (rd_data[1:0] == 2'b00))
    else $error("Status read returned wrong value.");

  a_sticky_set: assert property (
    (|status_chg) |=> ((state_q.irq_stat & $past(status_chg)) == $past(status_chg)))
    else $error("Status change lost from sticky register.");

  // High-speed select must always tristate the differential pair.
  a_hs_disable: assert property ( // R11
    state_q.rate[`RSC_BIT_HS_SEL]
    |-> !diff_155m_output_oe)
    else $error("Differential pair driven in high-speed mode.");

  // Below the clear threshold a set primary bit must drop at the tick.
  a_pri_clear_below: assert property ( // R02
    tick && state_q.status[`RSC_BIT_PRI] && (pri_mag < `RSC_OOR_CLR_TPPM)
    |=> !state_q.status[`RSC_BIT_PRI])
    else $error("Primary out-of-range bit did not clear below threshold.");

  // Inside the band a set primary bit must hold, which is the hysteresis.
  a_pri_hold_band: assert property ( // R02
    tick && state_q.status[`RSC_BIT_PRI] && (pri_mag >= `RSC_OOR_CLR_TPPM)
    |=> state_q.status[`RSC_BIT_PRI])
    else $error("Primary out-of-range bit cleared inside hysteresis band.");

  // A clear primary bit must not set at or below the set threshold.
  a_pri_stay_low: assert property ( // R01
    tick && !state_q.status[`RSC_BIT_PRI] && (pri_mag <= `RSC_OOR_SET_TPPM)
    |=> !state_q.status[`RSC_BIT_PRI])
    else $error("Primary out-of-range bit set without cause.");

  // The secondary bit sets above the same threshold as the primary.
  a_sec_set_above: assert property ( // R05
    tick && !state_q.status[`RSC_BIT_SEC] && (sec_mag > `RSC_OOR_SET_TPPM)
    |=> state_q.status[`RSC_BIT_SEC])
    else $error("Secondary out-of-range bit did not set above threshold.");

  // The secondary bit clears below the same threshold as the primary.
  a_sec_clear_below: assert property ( // R05
    tick && state_q.status[`RSC_BIT_SEC] && (sec_mag < `RSC_OOR_CLR_TPPM)
    |=> !state_q.status[`RSC_BIT_SEC])
    else $error("Secondary out-of-range bit did not clear below threshold.");

  // The secondary bit shares the once-per-period refresh.
  a_sec_only_tick: assert property ( // R05
    !tick
    |=> $stable(state_q.status[`RSC_BIT_SEC]))
    else $error("Secondary out-of-range bit changed between ticks.");

  // The refresh counter restarts after every tick, whatever the mode.
  a_tick_wrap: assert property ( // R03
    tick
    |=> (state_q.tick_cnt == 25'h0000000))
    else $error("Refresh counter did not restart after tick.");

  // The read data port idles at zero outside the answer cycle.
  a_rd_idle: assert property ( // R15
    !bus.rd
    |=> (rd_data == 8'h00))
    else $error("Read data not zero outside a read.");

  // With every source masked the interrupt line must stay low.
  a_irq_masked: assert property (
    (state_q.irq_mask == 8'h00)
    |-> !irq)
    else $error("Interrupt raised with all sources masked.");

  // A clear with no coincident change must empty the written bits.
  a_sticky_clear: assert property (
    bus.wr && (bus.addr == `RSC_ADDR_IRQ_STAT) && (status_chg == 8'h00)
    |=> ((state_q.irq_stat & $past(bus.wdata)) == 8'h00))
    else $error("Sticky bit survived its clear.");

  // Reserved rate bits never hold a one.
  a_rate_reserved: assert property ( // R15
    1'b1
    |-> (state_q.rate[5:0] == 6'h00))
    else $error("Reserved rate bits set.");

  // Reserved mask bits never hold a one.
  a_mask_reserved: assert property ( // R15
    1'b1
    |-> (state_q.irq_mask[3] == 1'b0) && (state_q.irq_mask[1:0] == 2'b00))
    else $error("Reserved mask bits set.");

  // Under software control the pins mirror the four status bits.
  a_pins_mirror: assert property ( // R14
    sw_control
    |=> (pins == state_q.status[7:4]))
    else $error("Status pins do not mirror the status bits.");

  // Well inside the tracking range the limit bit must be low.
  a_tracking_range_limit_inside: assert property ( // R09
    (core_mag < `RSC_TRACKING_RANGE_LIMIT_TPPM)
    |=> !state_q.status[`RSC_BIT_TRACKING_RANGE_LIMIT])
    else $error("Frequency limit bit set inside tracking range.");

  // A rate write lands in the next cycle with reserved bits dropped.
  a_write_rate: assert property ( // R10
    bus.wr && (bus.addr == `RSC_ADDR_RATE)
    |=> (state_q.rate == ($past(bus.wdata) & `RSC_RATE_WMASK)))
    else $error("Rate write did not land.");

  // A calibration write lands in the next cycle unchanged.
  a_write_cal: assert property ( // R04
    bus.wr && (bus.addr == `RSC_ADDR_OSC_CAL)
    |=> (state_q.cal == $past(bus.wdata)))
    else $error("Calibration write did not land.");

  // Writes to the read-only status address leave the rate untouched.
  a_status_ro: assert property ( // R15
    bus.wr && (bus.addr == `RSC_ADDR_STATUS)
    |=> $stable(state_q.rate))
    else $error("Write to status disturbed the rate register.");

  // At or above the limit threshold the limit bit must be high.
  a_tracking_range_limit_beyond: assert property ( // R08
    (core_mag >= `RSC_TRACKING_RANGE_LIMIT_TPPM)
    |=> state_q.status[`RSC_BIT_TRACKING_RANGE_LIMIT])
    else $error("Frequency limit bit low at tracking edge.");

  // Main scenarios worth seeing at least once.
  c_pri_set: cover property (tick ##1 $rose(state_q.status[`RSC_BIT_PRI]));
  c_pri_clr: cover property (tick ##1 $fell(state_q.status[`RSC_BIT_PRI]));
  c_hs_sel: cover property ($fell(diff_155m_output_oe));
  c_irq: cover property ($rose(irq));
  c_clear_vs_set: cover property (bus.wr && (bus.addr == `RSC_ADDR_IRQ_STAT)
                                  && |(bus.wdata & status_chg));

endmodule

/* File: hw/rsc_defs.svh */
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// Register byte addresses on the host port.
`define RSC_ADDR_STATUS    8'h01
`define RSC_ADDR_RATE      8'h04
`define RSC_ADDR_IRQ_STAT  8'h08
`define RSC_ADDR_IRQ_MASK  8'h09
`define RSC_ADDR_OSC_CAL   8'h0a

// Status register bit positions.
`define RSC_BIT_PRI        7
`define RSC_BIT_SEC        6
`define RSC_BIT_LOCK       5
`define RSC_BIT_HOLD       4
`define RSC_BIT_TRACKING_RANGE_LIMIT       2

// Output rate select bit positions.
`define RSC_BIT_HS_SEL     7
`define RSC_BIT_LR_SEL     6

// Reset values and implemented-bit masks.
`define RSC_RATE_RESET     8'h00
`define RSC_RATE_WMASK     8'hc0
`define RSC_STATUS_MASK    8'hf4
`define RSC_CAL_RESET      8'h00
`define RSC_IRQ_RESET      8'h00

// Frequency thresholds in units of 0.1 ppm.
`define RSC_OOR_SET_TPPM   17'h00078
`define RSC_OOR_CLR_TPPM   17'h0006e
`define RSC_LOCK_TPPM      17'h0058c
`define RSC_TRACKING_RANGE_LIMIT_TPPM      17'h00410

// Acceptance-range refresh period.
`define RSC_TICK_S         1
`define RSC_CLK_HZ         25000000
`define RSC_TICK_CYCLES    (`RSC_TICK_S * `RSC_CLK_HZ)

`endif

/* File: hw/rsc_pkg.sv */
package rsc_pkg;

  // Frequency carried by the combined low-rate output pin.
  typedef enum logic [1:0] {
    RSC_RATE_11M184,
    RSC_RATE_8M592,
    RSC_RATE_44M736,
    RSC_RATE_34M368
  } rsc_rate_t;

  // One host port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rsc_bus_req_t;

  // Offsets measured against the master oscillator, signed, 0.1 ppm units.
  typedef struct packed {
    logic [15:0] primary_offset;
    logic [15:0] secondary_offset;
    logic [15:0] core_offset;
    logic        holdover;
  } rsc_mon_t;

  // Dedicated status pins.
  typedef struct packed {
    logic primary_out_of_range;
    logic secondary_out_of_range;
    logic core_pll_locked;
    logic holdover;
  } rsc_pins_t;

  // Whole state of the block.
  typedef struct packed {
    logic [7:0]  rate;
    logic [7:0]  cal;
    logic [7:0]  status;
    logic [7:0]  irq_stat;
    logic [7:0]  irq_mask;
    logic [24:0] tick_cnt;
    logic [7:0]  rd_data;
    rsc_pins_t   pins;
    logic        diff_oe;
    rsc_rate_t   rate_out;
  } rsc_state_t;

endpackage

/* File: tb/test_ref_status_clock_select.sv */
`timescale 1ns/1ps
`include "rsc_defs.svh"

module test_ref_status_clock_select;
  // A short refresh period keeps the out-of-range tests brief.
  localparam int unsigned TICKS = 16;

  logic                  clk_sys;
  logic                  arst_n;
  rsc_pkg::rsc_bus_req_t bus;
  logic [7:0]            rd_data;
  rsc_pkg::rsc_mon_t     mon;
  logic                  sw_control;
  rsc_pkg::rsc_pins_t    pins;
  logic                  diff_oe;
  rsc_pkg::rsc_rate_t    rate_out;
  logic                  irq;
  int                    miscompares;
  int                    n_tests;

  rsc_ref_status_clock_select #(.TICK_CYCLES(TICKS)) u_dut (
    .clk_sys              (clk_sys),
    .arst_n               (arst_n),
    .bus                  (bus),
    .rd_data              (rd_data),
    .mon                  (mon),
    .sw_control           (sw_control),
    .pins                 (pins),
    .diff_155m_output_oe  (diff_oe),
    .combined_rate_output (rate_out),
    .irq                  (irq)
  );

  // Clock generation at 25 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; the short delay lets the write land before any check.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) bus <= '0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) bus <= '0;
    #1;
    chk(rd_data, exp);
  endtask

  // Waits past one whole refresh period plus the update latency.
  task automatic wait_tick();
    repeat (TICKS + 4) @(posedge clk_sys);
  endtask

  task automatic test_rate();
    rsc_pkg::rsc_rate_t exp_tab[4];
    logic [7:0]         v;
    exp_tab = '{rsc_pkg::RSC_RATE_11M184, rsc_pkg::RSC_RATE_8M592,
                rsc_pkg::RSC_RATE_44M736, rsc_pkg::RSC_RATE_34M368};
    rd_chk(`RSC_ADDR_RATE, 8'h00);
    chk({7'h00, diff_oe}, 8'h01);
    rd_chk(8'h02, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], 6'h3f};
      wr_reg(`RSC_ADDR_RATE, v);
      rd_chk(`RSC_ADDR_RATE, v & 8'hc0);
      chk({7'h00, diff_oe}, {7'h00, ~v[7]});
      chk({6'h00, rate_out}, {6'h00, exp_tab[i]});
    end
    $display("test_rate done");
  endtask

  task automatic test_core();
    @(posedge clk_sys) begin
      mon.core_offset <= 16'h0410;
      mon.holdover    <= 1'b1;
    end
    repeat (3) @(posedge clk_sys);
    rd_chk(`RSC_ADDR_STATUS, 8'h34);
    @(posedge clk_sys) begin
      mon.core_offset <= 16'hfa73;
      mon.holdover    <= 1'b0;
    end
    repeat (3) @(posedge clk_sys);
    rd_chk(`RSC_ADDR_STATUS, 8'h04);
    @(posedge clk_sys) mon.core_offset <= 16'h058c;
    repeat (3) @(posedge clk_sys);
    wr_reg(`RSC_ADDR_STATUS, 8'hff);
    rd_chk(`RSC_ADDR_STATUS, 8'h24);
    rd_chk(`RSC_ADDR_STATUS, 8'h24);
    @(posedge clk_sys) mon.core_offset <= 16'h0000;
    repeat (3) @(posedge clk_sys);
    rd_chk(`RSC_ADDR_STATUS, 8'h20);
    $display("test_core done");
  endtask

  task automatic test_range();
    @(posedge clk_sys) begin
      sw_control            <= 1'b1;
      mon.primary_offset    <= 16'h0079;
      mon.secondary_offset  <= 16'hff87;
    end
    wait_tick();
    rd_chk(`RSC_ADDR_STATUS, 8'he0);
    chk({4'h0, pins}, 8'h0e);
    // 11.5 ppm sits inside the hysteresis band, so only the secondary clears.
    @(posedge clk_sys) begin
      mon.primary_offset   <= 16'h0073;
      mon.secondary_offset <= 16'h0000;
    end
    wait_tick();
    rd_chk(`RSC_ADDR_STATUS, 8'ha0);
    @(posedge clk_sys) mon.primary_offset <= 16'h0064;
    wait_tick();
    rd_chk(`RSC_ADDR_STATUS, 8'h20);
    wr_reg(`RSC_ADDR_OSC_CAL, 8'h15);
    wait_tick();
    rd_chk(`RSC_ADDR_STATUS, 8'ha0);
    chk({4'h0, pins}, 8'h0a);
    @(posedge clk_sys) sw_control <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({4'h0, pins}, 8'h00);
    wr_reg(`RSC_ADDR_OSC_CAL, 8'h00);
    wait_tick();
    $display("test_range done");
  endtask

  task automatic test_irq();
    wr_reg(`RSC_ADDR_IRQ_MASK, 8'h00);
    wr_reg(`RSC_ADDR_IRQ_STAT, 8'hff);
    rd_chk(`RSC_ADDR_IRQ_STAT, 8'h00);
    @(posedge clk_sys) mon.holdover <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({7'h00, irq}, 8'h00);
    rd_chk(`RSC_ADDR_IRQ_STAT, 8'h10);
    wr_reg(`RSC_ADDR_IRQ_MASK, 8'h10);
    chk({7'h00, irq}, 8'h01);
    wr_reg(`RSC_ADDR_IRQ_STAT, 8'h20);
    chk({7'h00, irq}, 8'h01);
    wr_reg(`RSC_ADDR_IRQ_STAT, 8'h10);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk_sys) mon.holdover <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({7'h00, irq}, 8'h01);
    rd_chk(`RSC_ADDR_STATUS, 8'h20);
    $display("test_irq done");
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial begin
    miscompares = 0;
    n_tests     = 0;
    arst_n      = 1'b0;
    bus         = '0;
    mon         = '0;
    sw_control  = 1'b0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    test_rate();
    test_core();
    test_range();
    test_irq();
    print_verdict();
  end

  // The scenarios need well under a thousand cycles; a hang ends the run here.
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    print_verdict();
  end
endmodule
